// File: nip_pkg.sv
// Shared constants for the nested interrupt priority controller
`default_nettype none
package nip_pkg;
    localparam int NUM_SRC = 8;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_REQ = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_PRIO = 8'h0c;
    localparam logic [7:0] OFF_LAST = 8'h10;
    // Status word fields and reset values
    localparam int GIE_BIT = 7;
    localparam int ISV_BIT = 1;
    localparam logic [7:0] STATUS_RST = 8'h02;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [7:0] REQ_RST = 8'h00;
    // Vectors
    localparam logic [15:0] TRAP_VECTOR = 16'h003e;
    localparam logic [15:0] VECTOR_BASE = 16'h0004;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: nip_src_if.sv
// Carrier between the controller and its flag bank and picker
`timescale 1ns/100ps
`default_nettype none
interface nip_src_if;
    logic [nip_pkg::NUM_SRC-1:0] req;
    logic [nip_pkg::NUM_SRC-1:0] mask;
    logic [nip_pkg::NUM_SRC-1:0] prio;
    logic any;
    logic [nip_pkg::IDX_W-1:0] idx;
    logic best_prio;
    modport bank (output req);
    modport pick (input req, input mask, input prio, output any, output idx, output best_prio);
    modport ctl (input req, output mask, output prio, input any, input idx, input best_prio);
endinterface
`default_nettype wire

// File: nip_flag_bank.sv
// Per-source request flags
`timescale 1ns/100ps
`default_nettype none
module nip_flag_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [nip_pkg::NUM_SRC-1:0] set_vec,
    input wire logic [nip_pkg::NUM_SRC-1:0] clr_vec,
    input wire logic wr_en,
    input wire logic [nip_pkg::NUM_SRC-1:0] wr_data,
    nip_src_if.bank src
);
    logic [nip_pkg::NUM_SRC-1:0] req_q;
    logic [nip_pkg::NUM_SRC-1:0] req_d;

    genvar i;
    generate
        for (i = 0; i < nip_pkg::NUM_SRC; i++) begin : g_flag
            // A new request wins over a clear in the same cycle
            always_comb begin
                if (set_vec[i]) begin
                    req_d[i] = 1'b1;
                end else if (wr_en) begin
                    req_d[i] = wr_data[i] & ~clr_vec[i];
                end else begin
                    req_d[i] = req_q[i] & ~clr_vec[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= nip_pkg::REQ_RST;
        end else begin
            req_q <= req_d;
        end
    end

    assign src.req = req_q;
endmodule
`default_nettype wire

// File: nip_picker.sv
// Chooses the best eligible maskable request
`timescale 1ns/100ps
`default_nettype none
module nip_picker (
    nip_src_if.pick src
);
    logic [nip_pkg::NUM_SRC-1:0] elig;
    logic [nip_pkg::NUM_SRC-1:0] elig_hi;

    genvar i;
    generate
        for (i = 0; i < nip_pkg::NUM_SRC; i++) begin : g_elig
            assign elig[i] = src.req[i] & ~src.mask[i];
            assign elig_hi[i] = elig[i] & ~src.prio[i];
        end
    endgenerate

    // Programmable level first, then lowest index as the fixed order
    always_comb begin
        src.any = |elig;
        src.best_prio = ~(|elig_hi);
        src.idx = '0;
        for (int k = nip_pkg::NUM_SRC - 1; k >= 0; k--) begin
            if (src.best_prio ? elig[k] : elig_hi[k]) begin
                src.idx = nip_pkg::IDX_W'(k);
            end
        end
    end
endmodule
`default_nettype wire

// File: nip_ctrl.sv
// Interrupt acknowledgement controller with AXI4-Lite register access
// How it works
// - The software trap is always accepted, whatever enable, mask or level.
// - Trap acceptance saves status then PC, clears enable, vectors to trap word.
// - No new maskable interrupt is accepted unless global enable is set.
// - Any acceptance clears the global enable flag.
// - The enable instruction sets global enable for later decisions.
// - While enabled, equal or higher level nests; strictly lower does not.
// - Nesting uses the programmable level bit; fixed order only breaks ties.
// - Refused requests stay pending; after a return one instruction runs first.
// - In-service flag 0 means high handler; only high requests may nest.
// - In-service flag 1 means idle, low or trap handler; both may nest.
// - Source level bit 0 is high priority, 1 is low.
// - Status, return, enable, push/pop or flag accesses delay acceptance one instruction.
// - The trap does not delay; its enable clear blocks concurrent maskables.
// - A source level bit never affects setting its request flag.
// - A source is eligible when requested and unmasked, accepted only if enabled.
// - Maskable acceptance saves status, PC, clears enable, copies level to in-service.
// - Among simultaneous requests the higher level wins, then the fixed order.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module nip_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [nip_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [nip_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [nip_pkg::NUM_SRC-1:0] irq_src,
    input wire logic instr_end,
    input wire logic instr_hold,
    input wire logic software_trap_instr,
    input wire logic enable_irq_instr,
    input wire logic disable_irq_instr,
    input wire logic stack_restore,
    input wire logic [7:0] stack_status_word,
    output logic ack_pulse,
    output logic ack_trap,
    output logic [15:0] ack_vector,
    output logic [7:0] ack_status_word,
    output logic global_irq_enable,
    output logic in_service_priority
);
    nip_src_if src ();

    // Status and configuration
    logic gie_q, gie_d, isv_q, isv_d;
    logic [nip_pkg::NUM_SRC-1:0] mask_q, mask_d, prio_q, prio_d;
    logic [nip_pkg::NUM_SRC-1:0] clr_vec;
    logic bus_hold_q, bus_hold_d;
    logic [nip_pkg::IDX_W:0] last_q, last_d;
    // Acknowledge outputs
    logic ack_q, ack_d, trap_q, trap_d;
    logic [15:0] vec_q, vec_d;
    logic [7:0] stw_q, stw_d;
    // AXI state
    logic [nip_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // Decoded strobes
    logic wr_fire, wr_stat, wr_req, wr_mask, wr_prio, wr_hit;
    logic rd_fire, rd_hit, rd_flag;
    logic [7:0] status_now, rd_byte;
    logic accept_point, mask_ok;

    nip_flag_bank u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_vec(irq_src),
        .clr_vec(clr_vec),
        .wr_en(wr_req),
        .wr_data(wbyte_q),
        .src(src)
    );

    nip_picker u_pick (
        .src(src)
    );

    assign src.mask = mask_q;
    assign src.prio = prio_q;

    always_comb begin
        status_now = 8'h00;
        status_now[nip_pkg::GIE_BIT] = gie_q;
        status_now[nip_pkg::ISV_BIT] = isv_q;
    end

    // Write decode, taken once both address and data are held
    always_comb begin
        wr_fire = aw_have_q & w_have_q & ~bvalid_q;
        wr_stat = 1'b0;
        wr_req = 1'b0;
        wr_mask = 1'b0;
        wr_prio = 1'b0;
        wr_hit = 1'b1;
        if (awaddr_q == nip_pkg::OFF_STATUS) begin
            wr_stat = wr_fire & wlane_q;
        end else if (awaddr_q == nip_pkg::OFF_REQ) begin
            wr_req = wr_fire & wlane_q;
        end else if (awaddr_q == nip_pkg::OFF_MASK) begin
            wr_mask = wr_fire & wlane_q;
        end else if (awaddr_q == nip_pkg::OFF_PRIO) begin
            wr_prio = wr_fire & wlane_q;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_fire = s_axi_arvalid & arready_q;
        rd_hit = 1'b1;
        rd_flag = 1'b1;
        rd_byte = 8'h00;
        if (s_axi_araddr == nip_pkg::OFF_STATUS) begin
            rd_byte = status_now;
        end else if (s_axi_araddr == nip_pkg::OFF_REQ) begin
            rd_byte = src.req;
        end else if (s_axi_araddr == nip_pkg::OFF_MASK) begin
            rd_byte = mask_q;
        end else if (s_axi_araddr == nip_pkg::OFF_PRIO) begin
            rd_byte = prio_q;
        end else if (s_axi_araddr == nip_pkg::OFF_LAST) begin
            rd_byte = {4'h0, last_q};
            rd_flag = 1'b0;
        end else begin
            rd_hit = 1'b0;
            rd_flag = 1'b0;
        end
    end

    // AXI channel handshakes
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? nip_pkg::RESP_OKAY : nip_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rdata_d = {24'h000000, rd_byte};
            rresp_d = rd_hit ? nip_pkg::RESP_OKAY : nip_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // One write and one read in flight at a time
        awready_d = ~aw_have_d & ~bvalid_d & ~wr_fire;
        wready_d = ~w_have_d & ~bvalid_d & ~wr_fire;
        arready_d = ~rvalid_d;
    end

    // Maskable acceptance may only happen at the end of an instruction that does not hold
    always_comb begin
        accept_point = instr_end & ~instr_hold & ~bus_hold_q;
        mask_ok = src.any & gie_q & (isv_q | ~src.best_prio);
    end

    // Status word, configuration and acknowledge
    always_comb begin
        gie_d = gie_q;
        isv_d = isv_q;
        mask_d = mask_q;
        prio_d = prio_q;
        last_d = last_q;
        clr_vec = '0;
        ack_d = 1'b0;
        trap_d = 1'b0;
        vec_d = vec_q;
        stw_d = stw_q;
        // A bus access to the flag or status registers delays the next decision
        bus_hold_d = bus_hold_q;
        if (instr_end) begin
            bus_hold_d = 1'b0;
        end
        if ((wr_fire && wr_hit) || (rd_fire && rd_flag)) begin
            bus_hold_d = 1'b1;
        end
        if (wr_mask) begin
            mask_d = wbyte_q;
        end
        if (wr_prio) begin
            prio_d = wbyte_q;
        end
        if (wr_stat) begin
            gie_d = wbyte_q[nip_pkg::GIE_BIT];
            isv_d = wbyte_q[nip_pkg::ISV_BIT];
        end
        if (stack_restore) begin
            gie_d = stack_status_word[nip_pkg::GIE_BIT];
            isv_d = stack_status_word[nip_pkg::ISV_BIT];
        end
        if (enable_irq_instr) begin
            gie_d = 1'b1;
        end else if (disable_irq_instr) begin
            gie_d = 1'b0;
        end
        if (software_trap_instr) begin
            // Trap ignores enable, mask and level; it also shuts out maskables
            ack_d = 1'b1;
            trap_d = 1'b1;
            vec_d = nip_pkg::TRAP_VECTOR;
            stw_d = status_now;
            gie_d = 1'b0;
            last_d = {1'b1, nip_pkg::IDX_W'(0)};
        end else if (accept_point && mask_ok) begin
            ack_d = 1'b1;
            vec_d = nip_pkg::VECTOR_BASE + {12'h000, src.idx, 1'b0};
            stw_d = status_now;
            gie_d = 1'b0;
            isv_d = src.best_prio;
            clr_vec[src.idx] = 1'b1;
            last_d = {1'b0, src.idx};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_q <= nip_pkg::STATUS_RST[nip_pkg::GIE_BIT];
            isv_q <= nip_pkg::STATUS_RST[nip_pkg::ISV_BIT];
            mask_q <= nip_pkg::MASK_RST;
            prio_q <= nip_pkg::PRIO_RST;
            last_q <= '0;
            bus_hold_q <= 1'b0;
            ack_q <= 1'b0;
            trap_q <= 1'b0;
            vec_q <= 16'h0000;
            stw_q <= 8'h00;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= nip_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= nip_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            gie_q <= gie_d;
            isv_q <= isv_d;
            mask_q <= mask_d;
            prio_q <= prio_d;
            last_q <= last_d;
            bus_hold_q <= bus_hold_d;
            ack_q <= ack_d;
            trap_q <= trap_d;
            vec_q <= vec_d;
            stw_q <= stw_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign ack_pulse = ack_q;
    assign ack_trap = trap_q;
    assign ack_vector = vec_q;
    assign ack_status_word = stw_q;
    assign global_irq_enable = gie_q;
    assign in_service_priority = isv_q;
endmodule
`default_nettype wire

// File: nip_ctrl_asserts.sv
// Checker for the acknowledgement controller's core link
`timescale 1ns/100ps
`default_nettype none
module nip_ctrl_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_end,
    input wire logic instr_hold,
    input wire logic software_trap_instr,
    input wire logic enable_irq_instr,
    input wire logic disable_irq_instr,
    input wire logic stack_restore,
    input wire logic [7:0] stack_status_word,
    input wire logic ack_pulse,
    input wire logic ack_trap,
    input wire logic [15:0] ack_vector,
    input wire logic [7:0] ack_status_word,
    input wire logic global_irq_enable,
    input wire logic in_service_priority
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_trap;
        software_trap_instr |=> ack_pulse && ack_trap && ack_vector == 16'h003e;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken at its vector");
    property p_ack_ie;
        ack_pulse |-> !global_irq_enable;
    endproperty
    a_ack_ie: assert property (p_ack_ie) else $error("enable left set on acceptance");
    property p_disabled;
        !global_irq_enable && !software_trap_instr |=> !ack_pulse;
    endproperty
    a_disabled: assert property (p_disabled) else $error("accepted while disabled");
    property p_hold;
        instr_end && instr_hold && !software_trap_instr |=> !ack_pulse;
    endproperty
    a_hold: assert property (p_hold) else $error("accepted after hold instruction");
    property p_no_end;
        !instr_end && !software_trap_instr |=> !ack_pulse;
    endproperty
    a_no_end: assert property (p_no_end) else $error("accepted outside instruction end");
    property p_mask_vec;
        ack_pulse && !ack_trap |-> ack_status_word[7] && !ack_vector[0] && ack_vector inside {[16'h0004:16'h0012]};
    endproperty
    a_mask_vec: assert property (p_mask_vec) else $error("bad maskable acceptance");
    property p_isp_hi;
        ack_pulse && !ack_trap && !ack_status_word[1] |-> !in_service_priority;
    endproperty
    a_isp_hi: assert property (p_isp_hi) else $error("low request nested in high handler");
    property p_restore;
        stack_restore && instr_hold && !enable_irq_instr && !disable_irq_instr && !software_trap_instr
            |=> global_irq_enable == $past(stack_status_word[7]) && in_service_priority == $past(stack_status_word[1]);
    endproperty
    a_restore: assert property (p_restore) else $error("flags not restored");
    property p_ei;
        enable_irq_instr && instr_hold && !software_trap_instr |=> global_irq_enable;
    endproperty
    a_ei: assert property (p_ei) else $error("enable instruction ignored");
endmodule
bind nip_ctrl nip_ctrl_asserts i_nip_ctrl_asserts (.aclk, .aresetn, .instr_end, .instr_hold,
    .software_trap_instr, .enable_irq_instr, .disable_irq_instr, .stack_restore, .stack_status_word,
    .ack_pulse, .ack_trap, .ack_vector, .ack_status_word, .global_irq_enable, .in_service_priority);
`default_nettype wire

// File: nip_seq_model.sv
// Behavioural instruction sequencer with status stack
`timescale 1ns/100ps
`default_nettype none
module nip_seq_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ack_pulse,
    input wire logic [7:0] ack_status_word,
    output logic instr_end,
    output logic instr_hold,
    output logic software_trap_instr,
    output logic enable_irq_instr,
    output logic disable_irq_instr,
    output logic stack_restore,
    output logic [7:0] stack_status_word
);
    logic [7:0] stk [8];
    logic [2:0] sp;
    // Inverted off-cycle so a stale word is never mistaken for a pop
    assign stack_status_word = stack_restore ? stk[sp - 3'h1] : ~stk[sp - 3'h1];
    always @(posedge aclk) begin
        if (!aresetn)
            sp <= 3'h0;
        else if (ack_pulse) begin
            stk[sp] <= ack_status_word;
            sp <= sp + 3'h1;
        end else if (stack_restore)
            sp <= sp - 3'h1;
    end
    initial {instr_end, instr_hold, software_trap_instr, enable_irq_instr, disable_irq_instr, stack_restore} = 6'h00;
    // Order: end, hold, trap, enable, disable, restore; returns end as hold class
    task automatic op(input logic [5:0] v);
        {instr_end, instr_hold, software_trap_instr, enable_irq_instr, disable_irq_instr, stack_restore} <= v;
        @(posedge aclk);
        {instr_end, instr_hold, software_trap_instr, enable_irq_instr, disable_irq_instr, stack_restore} <= 6'h00;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// File: nip_ctrl_bench.sv
// Self-checking bench for the acknowledgement controller
`timescale 1ns/100ps
`default_nettype none
module nip_ctrl_bench;
    localparam logic [5:0] PLAIN = 6'h20;
    localparam logic [5:0] ENA = 6'h34;
    localparam logic [5:0] DIS = 6'h32;
    localparam logic [5:0] RET = 6'h31;
    localparam logic [5:0] TRAP = 6'h08;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ack_pulse, ack_trap;
    logic instr_end, instr_hold, software_trap_instr, enable_irq_instr, disable_irq_instr, stack_restore;
    logic global_irq_enable, in_service_priority;
    logic [7:0] s_axi_awaddr, s_axi_araddr, irq_src, stack_status_word, ack_status_word, last_sw;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] ack_vector, last_vec;
    logic last_trap;
    int n_fail = 0;
    int cmp_count = 0;
    int acks = 0;
    nip_ctrl i_nip_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_src,
        .instr_end, .instr_hold, .software_trap_instr, .enable_irq_instr, .disable_irq_instr, .stack_restore,
        .stack_status_word, .ack_pulse, .ack_trap, .ack_vector, .ack_status_word, .global_irq_enable,
        .in_service_priority);
    nip_seq_model i_nip_seq_model (.aclk, .aresetn, .ack_pulse, .ack_status_word, .instr_end, .instr_hold,
        .software_trap_instr, .enable_irq_instr, .disable_irq_instr, .stack_restore, .stack_status_word);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(negedge aclk) if (ack_pulse === 1'b1) begin
        acks++;
        last_vec = ack_vector;
        last_sw = ack_status_word;
        last_trap = ack_trap;
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic run(input logic [5:0] v, input int n, input logic [15:0] vec, input logic [7:0] sw);
        i_nip_seq_model.op(v);
        chk("ack count", 16'(n), 16'(acks));
        if (n > 0) begin
            chk("ack vector", vec, last_vec);
            chk("ack trap", {15'h0, v[3]}, {15'h0, last_trap});
            chk("saved status", {8'h00, sw}, {8'h00, last_sw});
        end
        acks = 0;
    endtask
    task automatic flags(input logic [1:0] e);
        @(negedge aclk);
        chk("enable and in-service", {14'h0, e}, {14'h0, global_irq_enable, in_service_priority});
        @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", {14'h0, r}, {14'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk("rdata", {8'h00, d}, s_axi_rdata[15:0]);
        chk("rdata high", 16'h0000, s_axi_rdata[31:16]);
        chk("rresp", {14'h0, r}, {14'h0, s_axi_rresp});
    endtask
    task automatic fire(input logic [7:0] v);
        irq_src <= v;
        @(posedge aclk);
        irq_src <= 8'h00;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        n_fail++;
        close_out;
    end
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, irq_src} = 24'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 8'h02, 2'h0);
        rd(8'h08, 8'hff, 2'h0);
        rd(8'h0c, 8'hff, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        rd(8'h14, 8'h00, 2'h2);
        wr(8'h08, 8'hd5, 2'h0);
        wr(8'h0c, 8'hd7, 2'h0);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(TRAP, 1, 16'h003e, 8'h02);
        flags(2'b01);
        run(RET, 0, 16'h0, 8'h0);
        flags(2'b01);
        fire(8'h2a);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(ENA, 0, 16'h0, 8'h0);
        run(PLAIN, 1, 16'h000a, 8'h82);
        flags(2'b00);
        run(ENA, 0, 16'h0, 8'h0);
        run(PLAIN, 1, 16'h000e, 8'h80);
        run(ENA, 0, 16'h0, 8'h0);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(RET, 0, 16'h0, 8'h0);
        flags(2'b10);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(RET, 0, 16'h0, 8'h0);
        flags(2'b11);
        run(PLAIN, 1, 16'h0006, 8'h82);
        wr(8'h0c, 8'h00, 2'h0);
        fire(8'h01);
        rd(8'h04, 8'h01, 2'h0);
        wr(8'h0c, 8'hff, 2'h0);
        fire(8'h80);
        rd(8'h04, 8'h81, 2'h0);
        rd(8'h10, 8'h01, 2'h0);
        wr(8'h20, 8'h55, 2'h2);
        wr(8'h08, 8'h00, 2'h0);
        run(ENA, 0, 16'h0, 8'h0);
        run(TRAP | PLAIN, 1, 16'h003e, 8'h82);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(ENA, 0, 16'h0, 8'h0);
        rd(8'h04, 8'h81, 2'h0);
        run(PLAIN, 0, 16'h0, 8'h0);
        run(PLAIN, 1, 16'h0004, 8'h82);
        run(ENA, 0, 16'h0, 8'h0);
        run(DIS, 0, 16'h0, 8'h0);
        run(PLAIN, 0, 16'h0, 8'h0);
        close_out;
    end
endmodule
`default_nettype wire
